// ==== hdl/rtc_regs_top.sv ====
// real-time counter registers with axi4-lite slave
`default_nettype none
`include "rtc_defs.svh"
module rtc_regs_top
    import rtc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        debug_halt,
    output logic [31:0]      counter_value,
    output logic             sync_in_progress,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    import rtc_pkg::*;

    localparam int SYNC_N = `SYNC_CYC;

    logic              en_q;
    count_mode_t       mode_q;
    logic              twelve_q;
    logic              dbg_q;
    logic [7:0]        trim_q;
    logic [31:0]       count_q;
    logic [15:0]       per_q;
    logic              flag_q;
    sync_state_t       state_q;
    logic [`SYNC_W-1:0] sync_cnt_q;
    pend_t             pend_q;
    logic [31:0]       pend_data_q;
    logic              aw_got_q;
    logic              w_got_q;
    logic [7:0]        awaddr_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              rvalid_q;
    logic [31:0]       rdata_q;
    logic [1:0]        rresp_q;
    logic              wr_fire;
    logic              sync_start;
    logic              sync_fin;
    logic              tick;
    logic              run;
    logic [5:0]        wr_idx;
    logic [31:0]       merged;
    logic [31:0]       cal_next;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic mapped(input logic [5:0] idx);
        mapped = idx inside {`IDX_CTRL, `IDX_FLAG, `IDX_STATUS, `IDX_DBG,
                             `IDX_TRIM, `IDX_COUNT, `IDX_PER};
    endfunction : mapped

    function automatic logic [31:0] reg_val(input logic [5:0] idx);
        reg_val = `RST_WORD;
        unique case (idx)
            `IDX_CTRL: begin
                reg_val[`CTRL_EN]                    = en_q;
                reg_val[`CTRL_MODE_LO+1:`CTRL_MODE_LO] = mode_q;
                reg_val[`CTRL_TWELVE]                = twelve_q;
            end
            `IDX_FLAG:   reg_val[`FLAG_DONE] = flag_q;
            `IDX_STATUS: reg_val[`STAT_BUSY] = (state_q == SY_BUSY);
            `IDX_DBG:    reg_val[0]          = dbg_q;
            `IDX_TRIM:   reg_val[7:0]        = trim_q;
            `IDX_COUNT: begin
                if (mode_q == MODE_NARROW) begin
                    reg_val[15:0] = count_q[15:0];
                end else begin
                    reg_val = count_q;
                end
            end
            `IDX_PER:    reg_val[15:0]       = per_q;
            default:     reg_val             = `RST_WORD;
        endcase
    endfunction : reg_val

    function automatic logic [4:0] month_len(input logic [5:0] yr,
                                             input logic [3:0] mon);
        unique case (mon)
            4'h2:                   month_len = (yr[1:0] == 2'h0) ?
                                                5'h1D : 5'h1C;
            4'h4, 4'h6, 4'h9, 4'hB: month_len = 5'h1E;
            default:                month_len = 5'h1F;
        endcase
    endfunction : month_len

    // ------------------------------------------------------------
    // axi4-lite write channels
    // ------------------------------------------------------------
    assign s_axi_awready = !aw_got_q && !bvalid_q && (state_q == SY_IDLE);
    assign s_axi_wready  = !w_got_q && !bvalid_q && (state_q == SY_IDLE);
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign wr_fire       = aw_got_q && w_got_q && !bvalid_q;
    assign wr_idx        = awaddr_q[7:2];

    always_comb begin
        merged = reg_val(wr_idx);
        for (int b = 0; b < 4; b++) begin
            if (wstrb_q[b]) begin
                merged[b*8 +: 8] = wdata_q[b*8 +: 8];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            aw_got_q <= 1'b0;
            awaddr_q <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_got_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            w_got_q <= 1'b0;
            wdata_q <= `RST_WORD;
            wstrb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_got_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bvalid_q <= 1'b0;
            bresp_q  <= 2'h0;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= mapped(wr_idx) ? 2'h0 : 2'h2;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channels
    // ------------------------------------------------------------
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q  <= `RST_WORD;
            rresp_q  <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q  <= reg_val(s_axi_araddr[7:2]);
            rresp_q  <= mapped(s_axi_araddr[7:2]) ? 2'h0 : 2'h2;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // synchronisation sequencer
    // ------------------------------------------------------------
    assign sync_start = wr_fire && wr_idx inside {`IDX_CTRL, `IDX_TRIM,
                                                  `IDX_COUNT, `IDX_PER};
    assign sync_fin   = (state_q == SY_BUSY) &&
                        (sync_cnt_q == `SYNC_W'(`SYNC_CYC - 1));
    assign sync_in_progress = (state_q == SY_BUSY);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q    <= SY_IDLE;
            sync_cnt_q <= '0;
        end else if (sync_start) begin
            state_q    <= SY_BUSY;
            sync_cnt_q <= '0;
        end else if (sync_fin) begin
            state_q    <= SY_IDLE;
        end else if (state_q == SY_BUSY) begin
            sync_cnt_q <= sync_cnt_q + `SYNC_W'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pend_q      <= PD_CTRL;
            pend_data_q <= `RST_WORD;
        end else if (sync_start) begin
            pend_data_q <= merged;
            unique case (wr_idx)
                `IDX_TRIM:  pend_q <= PD_TRIM;
                `IDX_COUNT: pend_q <= PD_COUNT;
                `IDX_PER:   pend_q <= PD_PER;
                default:    pend_q <= merged[`CTRL_SWRST] ?
                                      PD_SWRST : PD_CTRL;
            endcase
        end
    end

    // ------------------------------------------------------------
    // control, trim, period and flag registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n || (sync_fin && pend_q == PD_SWRST)) begin
            en_q     <= 1'b0;
            mode_q   <= MODE_WIDE;
            twelve_q <= 1'b0;
        end else if (sync_fin && pend_q == PD_CTRL) begin
            en_q     <= pend_data_q[`CTRL_EN];
            mode_q   <= count_mode_t'(pend_data_q[`CTRL_MODE_LO +: 2]);
            twelve_q <= pend_data_q[`CTRL_TWELVE];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            dbg_q <= 1'b0;
        end else if (wr_fire && wr_idx == `IDX_DBG) begin
            dbg_q <= merged[0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n || (sync_fin && pend_q == PD_SWRST)) begin
            trim_q <= `RST_BYTE;
        end else if (sync_fin && pend_q == PD_TRIM) begin
            trim_q <= pend_data_q[7:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n || (sync_fin && pend_q == PD_SWRST)) begin
            per_q <= `RST_HALF;
        end else if (sync_fin && pend_q == PD_PER) begin
            per_q <= pend_data_q[15:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else if (sync_fin &&
                     pend_q inside {PD_TRIM, PD_COUNT, PD_PER}) begin
            flag_q <= 1'b1;
        end else if (sync_fin && pend_q == PD_SWRST) begin
            flag_q <= 1'b0;
        end else if (wr_fire && wr_idx == `IDX_FLAG &&
                     merged[`FLAG_DONE]) begin
            flag_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // counting
    // ------------------------------------------------------------
    rtc_rate_prescaler u_presc (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .run     (en_q),
        .trim    (trim_q),
        .tick    (tick)
    );

    assign run = tick && !(debug_halt && !dbg_q);

    always_comb begin
        logic [5:0] sec;
        logic [5:0] mnt;
        logic [3:0] hr;
        logic       pm;
        logic [4:0] h24;
        logic [4:0] day;
        logic [3:0] mon;
        logic [5:0] yr;
        logic       carry;
        sec   = count_q[`SEC_LO +: 6];
        mnt   = count_q[`MIN_LO +: 6];
        hr    = count_q[`HOUR_LO +: 4];
        pm    = count_q[`HOUR_PM];
        h24   = count_q[`HOUR_LO +: 5];
        day   = count_q[`DAY_LO +: 5];
        mon   = count_q[`MON_LO +: 4];
        yr    = count_q[`YEAR_LO +: 6];
        carry = 1'b0;
        if (sec == 6'd59) begin
            sec = 6'd0;
            if (mnt == 6'd59) begin
                mnt = 6'd0;
                if (twelve_q) begin
                    carry = (hr == 4'd11) && pm;
                    if (hr == 4'd11) begin
                        hr = 4'd12;
                        pm = !pm;
                    end else if (hr == 4'd12) begin
                        hr = 4'd1;
                    end else begin
                        hr = hr + 4'd1;
                    end
                    h24 = {pm, hr};
                end else if (h24 == 5'd23) begin
                    h24   = 5'd0;
                    carry = 1'b1;
                end else begin
                    h24 = h24 + 5'd1;
                end
            end else begin
                mnt = mnt + 6'd1;
            end
        end else begin
            sec = sec + 6'd1;
        end
        if (carry) begin
            if (day == month_len(yr, mon)) begin
                day = 5'd1;
                if (mon == 4'd12) begin
                    mon = 4'd1;
                    yr  = yr + 6'd1;
                end else begin
                    mon = mon + 4'd1;
                end
            end else begin
                day = day + 5'd1;
            end
        end
        cal_next = {yr, mon, day, h24, mnt, sec};
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n || (sync_fin && pend_q == PD_SWRST)) begin
            count_q <= `RST_WORD;
        end else if (sync_fin && pend_q == PD_COUNT) begin
            count_q <= (mode_q == MODE_NARROW) ?
                       {16'h0000, pend_data_q[15:0]} : pend_data_q;
        end else if (run) begin
            unique case (mode_q)
                MODE_NARROW: count_q <= (count_q[15:0] == per_q) ?
                    `RST_WORD :
                    {16'h0000, count_q[15:0] + 16'h0001};
                MODE_CAL:    count_q <= cal_next;
                default:     count_q <= count_q + 32'h00000001;
            endcase
        end
    end

    assign counter_value = count_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    busy_start_a: assert property (sync_start |=> sync_in_progress)
        else $error("busy did not rise on synchronised write");
    busy_end_a: assert property ($rose(sync_in_progress) |->
        ##SYNC_N !sync_in_progress)
        else $error("busy did not end after sync time");
    flag_set_a: assert property ($fell(sync_in_progress) &&
        pend_q inside {PD_TRIM, PD_COUNT, PD_PER} |-> flag_q)
        else $error("done flag missing after sync");
    flag_quiet_a: assert property ($fell(sync_in_progress) &&
        pend_q inside {PD_CTRL, PD_SWRST} && !$past(flag_q) |-> !flag_q)
        else $error("done flag set by enable or soft reset");
    dbg_keep_a: assert property ($fell(sync_in_progress) &&
        pend_q == PD_SWRST |-> dbg_q == $past(dbg_q))
        else $error("debug-run bit lost on soft reset");
    halt_hold_a: assert property (debug_halt && !dbg_q &&
        !sync_fin |=> $stable(count_q))
        else $error("counter moved while halted");
    narrow_wrap_a: assert property (mode_q == MODE_NARROW && run &&
        !sync_fin && count_q[15:0] == per_q |=> count_q == `RST_WORD)
        else $error("narrow counter missed period wrap");
    wide_inc_a: assert property (mode_q == MODE_WIDE && run &&
        !sync_fin |=> count_q == $past(count_q) + 32'h00000001)
        else $error("wide counter did not step");
    sec_wrap_a: assert property (mode_q == MODE_CAL && run &&
        !sync_fin && count_q[5:0] == 6'd59 |=> count_q[5:0] == 6'd0)
        else $error("seconds did not wrap");

    flag_rise_c: cover property ($rose(flag_q));
    narrow_wrap_c: cover property (mode_q == MODE_NARROW && run &&
        count_q[15:0] == per_q);
    pm_flip_c: cover property (mode_q == MODE_CAL && twelve_q &&
        $changed(count_q[`HOUR_PM]));
endmodule : rtc_regs_top
`default_nettype wire

// ==== include/rtc_defs.svh ====
// register offsets, field positions, reset values and timing counts
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH

`define IDX_CTRL      6'h00
`define IDX_FLAG      6'h08
`define IDX_STATUS    6'h0A
`define IDX_DBG       6'h0B
`define IDX_TRIM      6'h0C
`define IDX_COUNT     6'h10
`define IDX_PER       6'h14

`define CTRL_SWRST    0
`define CTRL_EN       1
`define CTRL_MODE_LO  2
`define CTRL_TWELVE   4
`define FLAG_DONE     6
`define STAT_BUSY     7
`define TRIM_SIGN     7

`define SEC_LO        0
`define MIN_LO        6
`define HOUR_LO       12
`define HOUR_PM       16
`define DAY_LO        17
`define MON_LO        22
`define YEAR_LO       26

`define RST_BYTE      8'h00
`define RST_HALF      16'h0000
`define RST_WORD      32'h00000000

`define SYNC_CYC      3
`define SYNC_W        2
`define PRESC_DIV     16
`define PRESC_W       5
`define TRIM_WIN      128

`endif

// ==== include/rtc_pkg.sv ====
// types shared by the counter block
`default_nettype none
package rtc_pkg;
    typedef enum logic [1:0] {MODE_WIDE, MODE_NARROW, MODE_CAL} count_mode_t;
    typedef enum logic {SY_IDLE, SY_BUSY} sync_state_t;
    typedef enum logic [2:0] {PD_CTRL, PD_SWRST, PD_TRIM, PD_COUNT,
                              PD_PER} pend_t;
endpackage : rtc_pkg
`default_nettype wire

// ==== hdl/rtc_rate_prescaler.sv ====
// prescaler producing count ticks with signed rate trim
`default_nettype none
`include "rtc_defs.svh"
module rtc_rate_prescaler (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic [7:0] trim,
    output logic            tick
);
    logic [`PRESC_W-1:0] div_q;
    logic [6:0]          win_q;
    logic [`PRESC_W-1:0] lim;
    logic                adj;

    // ------------------------------------------------------------
    // trimmed divide limit
    // ------------------------------------------------------------
    always_comb begin
        adj = (trim[6:0] != 7'h00) && (win_q < trim[6:0]);
        lim = `PRESC_W'(`PRESC_DIV - 1);
        if (adj && !trim[`TRIM_SIGN]) begin
            lim = `PRESC_W'(`PRESC_DIV);
        end else if (adj) begin
            lim = `PRESC_W'(`PRESC_DIV - 2);
        end
    end

    assign tick = run && (div_q == lim);

    always_ff @(posedge sys_clk) begin
        if (!rst_n || !run) begin
            div_q <= '0;
        end else if (tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + `PRESC_W'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n || !run) begin
            win_q <= 7'h00;
        end else if (tick) begin
            win_q <= win_q + 7'h01;
        end
    end
endmodule : rtc_rate_prescaler
`default_nettype wire

// ==== tb/rtc_counter_calendar_regs_tb.sv ====
// self-checking bench for the real-time counter register block
`default_nettype none
`include "rtc_defs.svh"
module rtc_counter_calendar_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // signals, clock and design
    // ------------------------------------------------------------
    logic        sys_clk, rst_n, debug_halt, busy;
    logic [31:0] cv, w_d, r_d, rdat;
    logic [7:0]  aw_a, ar_a;
    logic [3:0]  w_s;
    logic [1:0]  b_s, r_s, resp;
    logic        aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r;
    int          fail_count = 0;
    int          total_checks = 0;
    int          n;

    rtc_regs_top dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .debug_halt(debug_halt), .counter_value(cv),
        .sync_in_progress(busy), .s_axi_awaddr(aw_a),
        .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(w_d),
        .s_axi_wstrb(w_s), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
        .s_axi_bresp(b_s), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
        .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
        .s_axi_rdata(r_d), .s_axi_rresp(r_s), .s_axi_rvalid(r_v),
        .s_axi_rready(r_r));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task close_out;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic ad, dd;
        ad = 1'b0;
        dd = 1'b0;
        aw_a <= a;
        aw_v <= 1'b1;
        w_d  <= d;
        w_s  <= 4'hF;
        w_v  <= 1'b1;
        b_r  <= 1'b1;
        while (!(ad && dd)) begin
            @(posedge sys_clk);
            if (aw_v && aw_r === 1'b1) begin
                ad = 1'b1;
                aw_v <= 1'b0;
            end
            if (w_v && w_r === 1'b1) begin
                dd = 1'b1;
                w_v <= 1'b0;
            end
        end
        do @(posedge sys_clk); while (b_v !== 1'b1);
        resp = b_s;
        b_r <= 1'b0;
        @(posedge sys_clk);
    endtask : wr

    task rd(input logic [7:0] a);
        ar_a <= a;
        ar_v <= 1'b1;
        r_r  <= 1'b1;
        do @(posedge sys_clk); while (ar_r !== 1'b1);
        ar_v <= 1'b0;
        do @(posedge sys_clk); while (r_v !== 1'b1);
        rdat = r_d;
        resp = r_s;
        r_r <= 1'b0;
        @(posedge sys_clk);
    endtask : rd

    task idle;
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 20) begin
            @(posedge sys_clk);
            k++;
        end
    endtask : idle

    task tick_gap(output int g);
        logic [31:0] v;
        v = cv;
        g = 0;
        do begin
            @(posedge sys_clk);
            g++;
        end while (cv === v && g < 64);
    endtask : tick_gap

    function automatic logic [31:0] pk(input int y, mo, d, h, mi, s);
        return {y[5:0], mo[3:0], d[4:0], h[4:0], mi[5:0], s[5:0]};
    endfunction : pk
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_reset;
        rd(8'h30); check(rdat, 32'h0);
        rd(8'h40); check(rdat, 32'h0);
        rd(8'h50); check(rdat, 32'h0);
        rd(8'h2C); check(rdat, 32'h0);
        rd(8'h60); check(resp, 2'h2);
        wr(8'h60, 32'h0); check(resp, 2'h2);
        $display("test reset values done");
    endtask : t_reset

    task t_sync;
        wr(8'h30, 32'hA5);
        check(busy, 1'b1);
        check(resp, 2'h0);
        idle;
        check(busy, 1'b0);
        rd(8'h20); check(rdat[6], 1'b1);
        rd(8'h30); check(rdat, 32'hA5);
        wr(8'h20, 32'h40);
        wr(8'h00, 32'h0);
        idle;
        rd(8'h20); check(rdat[6], 1'b0);
        $display("test synchronised write done");
    endtask : t_sync

    task t_soft;
        wr(8'h2C, 32'h1);
        wr(8'h30, 32'h7F);
        wr(8'h00, 32'h1);
        idle;
        rd(8'h2C); check(rdat[0], 1'b1);
        rd(8'h30); check(rdat, 32'h0);
        rd(8'h20); check(rdat[6], 1'b0);
        $display("test soft reset done");
    endtask : t_soft

    task t_debug;
        logic [31:0] v;
        wr(8'h00, 32'h2);
        idle;
        debug_halt <= 1'b1;
        tick_gap(n); check(n < 64, 1'b1);
        wr(8'h2C, 32'h0);
        v = cv;
        repeat (40) @(posedge sys_clk);
        check(cv, v);
        debug_halt <= 1'b0;
        $display("test debug halt done");
    endtask : t_debug

    task t_rate;
        logic [7:0] t;
        int s;
        wr(8'h30, 32'h0);
        idle;
        tick_gap(n);
        tick_gap(n); check(n, 16);
        for (int i = 0; i < 2; i++) begin
            t = i ? 8'hFF : 8'h7F;
            wr(8'h30, {24'h0, t});
            idle;
            tick_gap(n);
            s = 0;
            repeat (4) begin
                tick_gap(n);
                s += n;
            end
            check(t[7] ? s < 64 : s > 64, 1'b1);
        end
        wr(8'h40, 32'hFFFF_FFF0);
        idle;
        rd(8'h40); check(rdat[31:4], 28'hFFFFFFF);
        $display("test rate trim done");
    endtask : t_rate

    task t_narrow;
        logic [31:0] mx;
        wr(8'h50, 32'h3);
        wr(8'h00, 32'h6);
        wr(8'h40, 32'h0);
        idle;
        mx = 32'h0;
        repeat (200) begin
            @(posedge sys_clk);
            if (cv > mx) mx = cv;
        end
        check(mx, 32'h3);
        $display("test narrow mode done");
    endtask : t_narrow

    task cal(input logic [31:0] c, input logic [31:0] st, ex);
        wr(8'h00, c);
        wr(8'h40, st);
        idle;
        tick_gap(n);
        check(cv, ex);
    endtask : cal

    task t_cal;
        cal(32'hA, pk(0, 1, 1, 10, 59, 59), pk(0, 1, 1, 11, 0, 0));
        cal(32'hA, pk(0, 1, 31, 23, 59, 59), pk(0, 2, 1, 0, 0, 0));
        cal(32'hA, pk(0, 2, 28, 23, 59, 59), pk(0, 2, 29, 0, 0, 0));
        cal(32'hA, pk(1, 2, 28, 23, 59, 59), pk(1, 3, 1, 0, 0, 0));
        cal(32'hA, pk(3, 12, 31, 23, 59, 59), pk(4, 1, 1, 0, 0, 0));
        cal(32'h1A, pk(0, 1, 1, 11, 59, 59), pk(0, 1, 1, 28, 0, 0));
        $display("test calendar done");
    endtask : t_cal
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        {rst_n, debug_halt, aw_v, w_v, b_r, ar_v, r_r} <= '0;
        {aw_a, ar_a, w_d, w_s} <= '0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        t_reset;
        t_sync;
        t_soft;
        t_debug;
        t_rate;
        t_narrow;
        t_cal;
        close_out;
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        close_out;
    end
endmodule : rtc_counter_calendar_regs_tb
`default_nettype wire
